// file: rtl/itc_consts.svh
// Purpose: Named constants for the inductance threshold compare block
// Assumes: Byte-wide registers on a 7-bit serial address
// Notes: Included by the package and the design module
`ifndef ITC_CONSTS_SVH
`define ITC_CONSTS_SVH

// =============================================================
// Register addresses
`define ITC_ADDR_INT_FUNC 7'h0A
`define ITC_ADDR_UPPER_LOW 7'h16
`define ITC_ADDR_UPPER_HIGH 7'h17
`define ITC_ADDR_LOWER_LOW 7'h18
`define ITC_ADDR_LOWER_HIGH 7'h19
`define ITC_ADDR_STATUS 7'h20

// =============================================================
// Reset values and the zero code that clears the high flag via 0x0A
`define ITC_RST_BYTE 8'h00
`define ITC_RST_THRESH 16'h0000
`define ITC_INT_FUNC_CLEAR 8'h00

// =============================================================
// Status bit positions
`define ITC_ST_NO_OSC 7
`define ITC_ST_DRDY_LOW 6
`define ITC_ST_RES_HIGH 5
`define ITC_ST_RES_HYST 4
`define ITC_ST_IND_HIGH 3
`define ITC_ST_IND_HYST 2
`define ITC_ST_RESERVED 1
`define ITC_ST_POR 0

// =============================================================
// Serial frame layout
`define ITC_FRAME_BITS 5'h10
`define ITC_CMD_BITS 5'h08
`define ITC_BIT_ZERO 5'h00

`endif

// file: rtl/itc_pkg.sv
// Purpose: Shared types for the inductance threshold compare block
// Assumes: Constants come from itc_consts.svh
// Notes: Nothing here is imported; users write itc_pkg::name
`include "itc_consts.svh"

package itc_pkg;

   // =============================================================
   // Serial frame phase
   typedef enum logic [1:0] {
      ITC_IDLE,
      ITC_COMMAND,
      ITC_DATA,
      ITC_DONE
   } itc_phase_t;

   typedef logic [7:0] itc_byte_t;

endpackage : itc_pkg

// file: rtl/itc_threshold_compare.sv
// Purpose: Inductance threshold registers, comparators and status byte
// Assumes: Serial clock at most one eighth of mclk_in, mode 0, MSB first
// Notes: One 16-bit frame per chip select: R/W bit, 7-bit address, data
`timescale 1ns/10ps
`include "itc_consts.svh"

// Operation
// - The active upper threshold is high byte times 256 plus low byte.
// - A result above the upper threshold drives the high-compare flag low.
// - The upper low byte is buffered until the upper high byte is written.
// - The active lower threshold is high byte times 256 plus low byte.
// - A result below the lower threshold raises the hysteresis flag.
// - The lower low byte is buffered until the lower high byte is written.
// - All four threshold bytes take writes at any time and reset to zero.
// - The status byte is read-only, resets to zero and packs seven flags and a reserved zero bit.
// - The high flag latches low; only a zero write to 0x0A clears it.
// - The hysteresis flag is 0 above the upper, 1 below the lower bound.
// - Data-ready reads 0 while new data waits, 1 when none is there.
module itc_threshold_compare (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // Serial port pins
   input wire logic sclk_in,
   input wire logic csn_in,
   input wire logic sdi_in,
   output logic sdo_out,
   output logic sdo_oe_out,
   // Conversion cores
   input wire logic [15:0] ind_result_in,
   input wire logic ind_result_valid_in,
   input wire logic new_data_in,
   input wire logic res_high_compare_flag_in,
   input wire logic res_hysteresis_flag_in,
   input wire logic no_oscillation_error_in,
   input wire logic por_busy_in,
   // Block state
   output logic [15:0] ind_upper_threshold_out,
   output logic [15:0] ind_lower_threshold_out,
   output logic [7:0] converter_status_out,
   output logic [7:0] interrupt_function_select_out
);

   // =============================================================
   // Pin synchronisers
   logic [2:0] sclk_sync;
   logic [1:0] csn_sync;
   logic [1:0] sdi_sync;
   logic sclk_rise;
   logic sclk_fall;

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sclk_sync <= 3'h0;
         csn_sync <= 2'h3;
         sdi_sync <= 2'h0;
      end else begin
         sclk_sync <= {sclk_sync[1:0], sclk_in};
         csn_sync <= {csn_sync[0], csn_in};
         sdi_sync <= {sdi_sync[0], sdi_in};
      end
   end

   // Edge detect looks only past the first stage
   assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
   assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];

   // =============================================================
   // Serial frame
   itc_pkg::itc_phase_t phase;
   logic [4:0] bit_cnt;
   logic [14:0] shift_in;
   logic [7:0] shift_out;
   logic is_read;
   logic [6:0] addr;
   logic wr_pulse;
   logic [7:0] wr_data;
   logic rd_status_pulse;
   logic [7:0] rd_data;
   logic [15:0] next_frame;

   assign next_frame = {shift_in, sdi_sync[1]};

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         phase <= itc_pkg::ITC_IDLE;
         bit_cnt <= `ITC_BIT_ZERO;
         shift_in <= 15'h0000;
         is_read <= 1'b0;
         addr <= 7'h00;
         wr_pulse <= 1'b0;
         wr_data <= `ITC_RST_BYTE;
         rd_status_pulse <= 1'b0;
      end else begin
         wr_pulse <= 1'b0;
         rd_status_pulse <= 1'b0;
         if (csn_sync[1]) begin
            phase <= itc_pkg::ITC_IDLE;
            bit_cnt <= `ITC_BIT_ZERO;
         end else if (sclk_rise) begin
            shift_in <= next_frame[14:0];
            bit_cnt <= bit_cnt + 5'h01;
            case (phase)
               itc_pkg::ITC_IDLE: begin
                  phase <= itc_pkg::ITC_COMMAND;
               end
               itc_pkg::ITC_COMMAND: begin
                  if (bit_cnt == `ITC_CMD_BITS - 5'h01) begin
                     phase <= itc_pkg::ITC_DATA;
                     is_read <= next_frame[7];
                     addr <= next_frame[6:0];
                  end
               end
               itc_pkg::ITC_DATA: begin
                  if (bit_cnt == `ITC_FRAME_BITS - 5'h01) begin
                     phase <= itc_pkg::ITC_DONE;
                     wr_pulse <= ~is_read;
                     wr_data <= next_frame[7:0];
                     // Consumed only after the byte went out, not before
                     rd_status_pulse <= is_read &&
                        (addr == `ITC_ADDR_STATUS);
                  end
               end
               default: begin
                  phase <= itc_pkg::ITC_DONE;
               end
            endcase
         end
      end
   end

   // Read data goes out on falling edges so it is stable at the next rise
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         shift_out <= `ITC_RST_BYTE;
         sdo_out <= 1'b0;
         sdo_oe_out <= 1'b0;
      end else if (csn_sync[1]) begin
         sdo_out <= 1'b0;
         sdo_oe_out <= 1'b0;
      end else if (sclk_fall && phase == itc_pkg::ITC_DATA && is_read) begin
         if (bit_cnt == `ITC_CMD_BITS) begin
            sdo_out <= rd_data[7];
            shift_out <= {rd_data[6:0], 1'b0};
         end else begin
            sdo_out <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
         end
         sdo_oe_out <= 1'b1;
      end
   end

   // =============================================================
   // Threshold registers
   logic [7:0] upper_low_buf;
   logic [7:0] lower_low_buf;
   logic wr_int_func_zero;

   assign wr_int_func_zero = wr_pulse && addr == `ITC_ADDR_INT_FUNC &&
      wr_data == `ITC_INT_FUNC_CLEAR;

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         upper_low_buf <= `ITC_RST_BYTE;
         lower_low_buf <= `ITC_RST_BYTE;
         ind_upper_threshold_out <= `ITC_RST_THRESH;
         ind_lower_threshold_out <= `ITC_RST_THRESH;
         interrupt_function_select_out <= `ITC_RST_BYTE;
      end else if (wr_pulse) begin
         // No mode gating: thresholds may change mid-conversion
         case (addr)
            `ITC_ADDR_UPPER_LOW: upper_low_buf <= wr_data;
            `ITC_ADDR_UPPER_HIGH: begin
               ind_upper_threshold_out <= {wr_data, upper_low_buf};
            end
            `ITC_ADDR_LOWER_LOW: lower_low_buf <= wr_data;
            `ITC_ADDR_LOWER_HIGH: begin
               ind_lower_threshold_out <= {wr_data, lower_low_buf};
            end
            `ITC_ADDR_INT_FUNC: interrupt_function_select_out <= wr_data;
            default: begin
            end
         endcase
      end
   end

   // =============================================================
   // Comparators and flags
   logic ind_high_compare_flag;
   logic ind_hysteresis_flag;
   logic data_ready_low;
   logic above_upper;
   logic below_lower;

   assign above_upper = ind_result_valid_in &&
      ind_result_in > ind_upper_threshold_out;
   assign below_lower = ind_result_valid_in &&
      ind_result_in < ind_lower_threshold_out;

   // Latching flag: the exceed event wins over a clear in the same cycle
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ind_high_compare_flag <= 1'b0;
      end else if (above_upper) begin
         ind_high_compare_flag <= 1'b0;
      end else if (wr_int_func_zero) begin
         ind_high_compare_flag <= 1'b1;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ind_hysteresis_flag <= 1'b0;
      end else if (above_upper) begin
         ind_hysteresis_flag <= 1'b0;
      end else if (below_lower) begin
         ind_hysteresis_flag <= 1'b1;
      end
      // Otherwise held inside the band
   end

   // New data wins over the status read that marks it consumed
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         data_ready_low <= 1'b0;
      end else if (new_data_in) begin
         data_ready_low <= 1'b0;
      end else if (rd_status_pulse) begin
         data_ready_low <= 1'b1;
      end
   end

   // =============================================================
   // Status byte and read mux
   logic [7:0] next_status;

   always_comb begin
      next_status = `ITC_RST_BYTE;
      next_status[`ITC_ST_NO_OSC] = no_oscillation_error_in;
      next_status[`ITC_ST_DRDY_LOW] = data_ready_low;
      next_status[`ITC_ST_RES_HIGH] = res_high_compare_flag_in;
      next_status[`ITC_ST_RES_HYST] = res_hysteresis_flag_in;
      next_status[`ITC_ST_IND_HIGH] = ind_high_compare_flag;
      next_status[`ITC_ST_IND_HYST] = ind_hysteresis_flag;
      next_status[`ITC_ST_RESERVED] = 1'b0;
      next_status[`ITC_ST_POR] = por_busy_in;
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         converter_status_out <= `ITC_RST_BYTE;
      end else begin
         converter_status_out <= next_status;
      end
   end

   // Status writes fall into the default branch and are dropped
   always_comb begin
      case (addr)
         `ITC_ADDR_INT_FUNC: rd_data = interrupt_function_select_out;
         `ITC_ADDR_UPPER_LOW: rd_data = upper_low_buf;
         `ITC_ADDR_UPPER_HIGH: rd_data = ind_upper_threshold_out[15:8];
         `ITC_ADDR_LOWER_LOW: rd_data = lower_low_buf;
         `ITC_ADDR_LOWER_HIGH: rd_data = ind_lower_threshold_out[15:8];
         `ITC_ADDR_STATUS: rd_data = converter_status_out;
         default: rd_data = `ITC_RST_BYTE;
      endcase
   end

endmodule : itc_threshold_compare

// file: tb/itc_checker.sv
// Purpose: Port assertions for the threshold compare block
// Assumes: Status byte lags its inputs by one edge
// Notes: Bound to the design after the module
`timescale 1ns/10ps
module itc_checker (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // Watched ports
   input wire logic csn_in,
   input wire logic sdo_oe_out,
   input wire logic [15:0] ind_result_in,
   input wire logic ind_result_valid_in,
   input wire logic new_data_in,
   input wire logic no_oscillation_error_in,
   input wire logic por_busy_in,
   input wire logic [15:0] ind_upper_threshold_out,
   input wire logic [15:0] ind_lower_threshold_out,
   input wire logic [7:0] converter_status_out
);
   logic [3:0] idle;
   logic above;
   logic below;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   assign above = ind_result_valid_in &&
      ind_result_in > ind_upper_threshold_out;
   assign below = ind_result_valid_in &&
      ind_result_in < ind_lower_threshold_out;
   // ==========
   // Idle count, long enough for synced writes to land
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         idle <= 4'h0;
      end else if (!csn_in) begin
         idle <= 4'h0;
      end else if (idle != 4'hF) begin
         idle <= idle + 4'h1;
      end
   end
   // ==========
   // Assertions
   chk_status_copy: assert property (
      $past(resetn_in) |-> {converter_status_out[7], converter_status_out[0]}
      == $past({no_oscillation_error_in, por_busy_in}))
      else $error("status copy wrong");
   chk_ready_low: assert property (
      new_data_in |-> ##2 !converter_status_out[6])
      else $error("data ready not low");
   chk_high_latch: assert property (
      above |-> ##2 !converter_status_out[3]) else $error("high flag missed");
   chk_hyst_above: assert property (
      above |-> ##2 !converter_status_out[2]) else $error("hyst not 0");
   chk_hyst_below: assert property (
      below && !above |-> ##2 converter_status_out[2])
      else $error("hyst not 1");
   chk_hyst_hold: assert property (
      ind_result_valid_in && !above && !below
      |-> ##2 $stable(converter_status_out[2])) else $error("hyst moved");
   chk_thresh_idle: assert property (
      idle > 4'h8 |-> $stable(ind_upper_threshold_out)
      && $stable(ind_lower_threshold_out)) else $error("threshold moved");
   chk_sdo_release: assert property (
      idle > 4'h8 |-> !sdo_oe_out) else $error("sdo still driven");
   cover property (above);
   cover property (below && !above);
   cover property (new_data_in);
endmodule : itc_checker

bind itc_threshold_compare itc_checker u_chk (.mclk_in, .resetn_in, .csn_in,
   .sdo_oe_out, .ind_result_in, .ind_result_valid_in, .new_data_in,
   .no_oscillation_error_in, .por_busy_in, .ind_upper_threshold_out,
   .ind_lower_threshold_out, .converter_status_out);

// file: tb/itc_host_model.sv
// Purpose: Serial host model, mode 0, MSB first
// Assumes: Half serial period of five clocks
// Notes: Serial clock stands low between frames
`timescale 1ns/10ps
module itc_host_model (
   // Clock
   input wire logic mclk_in,
   // Serial pins
   output logic sclk_out,
   output logic csn_out,
   output logic sdi_out,
   input wire logic sdo_in,
   input wire logic sdo_oe_in,
   // Read result
   output logic [7:0] rd_out,
   output logic rd_done_out
);
   initial begin
      sclk_out = 1'b0;
      csn_out = 1'b1;
      sdi_out = 1'b0;
      rd_out = 8'h00;
      rd_done_out = 1'b0;
   end
   // ==========
   // One frame: read flag, address, data
   task automatic xfer(input logic [15:0] frame);
      logic [7:0] sh;
      sh = 8'h00;
      csn_out = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi_out = frame[i];
         repeat (5) @(negedge mclk_in);
         sclk_out = 1'b1;
         // Undriven line reads as garbage, never as data
         sh = {sh[6:0], sdo_oe_in ? sdo_in : ~sdo_in};
         repeat (5) @(negedge mclk_in);
         sclk_out = 1'b0;
      end
      repeat (5) @(negedge mclk_in);
      csn_out = 1'b1;
      sdi_out = ~sdi_out;
      rd_out = sh;
      rd_done_out = frame[15];
      @(negedge mclk_in);
      rd_done_out = 1'b0;
      repeat (5) @(negedge mclk_in);
   endtask : xfer
endmodule : itc_host_model

// file: tb/itc_threshold_compare_tb.sv
// Purpose: Self-checking bench for the threshold compare block
// Assumes: Inputs change on the falling clock edge
// Notes: Serial reads are scored against a queue of masked notes
`timescale 1ns/10ps
module itc_threshold_compare_tb;
   localparam logic [15:0] UPR = 16'h9A3C;
   localparam logic [15:0] LWR = 16'h4021;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic sclk_in, csn_in, sdi_in, sdo_out, sdo_oe_out, rd_done;
   logic [15:0] ind_result_in = 16'h0000;
   logic ind_result_valid_in = 1'b0;
   logic new_data_in = 1'b0;
   logic res_high_compare_flag_in = 1'b0;
   logic res_hysteresis_flag_in = 1'b0;
   logic no_oscillation_error_in = 1'b0;
   logic por_busy_in = 1'b1;
   logic [15:0] ind_upper_threshold_out, ind_lower_threshold_out, note;
   logic [7:0] converter_status_out, interrupt_function_select_out, rd_data;
   logic [31:0] seed = 32'h40799523;
   logic hi_exp = 1'b0;
   logic hy_exp = 1'b0;
   logic rdy_exp = 1'b0;
   logic [15:0] q[$];
   int failures = 0;
   int check_count = 0;
   always #20 mclk_in = ~mclk_in;
   itc_threshold_compare dut (.mclk_in, .resetn_in, .sclk_in, .csn_in,
      .sdi_in, .sdo_out, .sdo_oe_out, .ind_result_in, .ind_result_valid_in,
      .new_data_in, .res_high_compare_flag_in, .res_hysteresis_flag_in,
      .no_oscillation_error_in, .por_busy_in, .ind_upper_threshold_out,
      .ind_lower_threshold_out, .converter_status_out,
      .interrupt_function_select_out);
   itc_host_model host (.mclk_in, .sclk_out(sclk_in), .csn_out(csn_in),
      .sdi_out(sdi_in), .sdo_in(sdo_out), .sdo_oe_in(sdo_oe_out),
      .rd_out(rd_data), .rd_done_out(rd_done));
   // ==========
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] st_exp();
      return {no_oscillation_error_in, rdy_exp, res_high_compare_flag_in,
         res_hysteresis_flag_in, hi_exp, hy_exp, 1'b0, por_busy_in};
   endfunction : st_exp
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic rd(input logic [6:0] a, input logic [7:0] m, e);
      q.push_back({m, e});
      host.xfer({1'b1, a, 8'h00});
   endtask : rd
   task automatic feed(input logic [15:0] r);
      @(negedge mclk_in);
      ind_result_in = r;
      ind_result_valid_in = 1'b1;
      if (r > UPR) {hi_exp, hy_exp} = 2'b00;
      else if (r < LWR) hy_exp = 1'b1;
      @(negedge mclk_in);
      ind_result_valid_in = 1'b0;
      @(negedge mclk_in);
      check(converter_status_out, st_exp());
   endtask : feed
   task automatic complete_run();
      $display("Checks %0d, failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   // ==========
   // Scoring and watchdog
   always @(posedge mclk_in) begin
      if (rd_done === 1'b1) begin
         note = q.pop_front();
         check(rd_data & note[15:8], note[7:0]);
      end
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      failures++;
      complete_run();
   end
   // ==========
   // Main sequence
   initial begin
      repeat (4) @(negedge mclk_in);
      resetn_in = 1'b1;
      repeat (2) @(negedge mclk_in);
      check(converter_status_out, st_exp());
      por_busy_in = 1'b0;
      rd(7'h20, 8'h01, 8'h00);
      rdy_exp = 1'b1;
      for (int a = 22; a <= 25; a++) rd(a[6:0], 8'hFF, 8'h00);
      host.xfer({8'h16, UPR[7:0]});
      check(ind_upper_threshold_out, 16'h0000);
      rd(7'h16, 8'hFF, UPR[7:0]);
      host.xfer({8'h17, UPR[15:8]});
      check(ind_upper_threshold_out, UPR);
      host.xfer({8'h18, LWR[7:0]});
      check(ind_lower_threshold_out, 16'h0000);
      host.xfer({8'h19, LWR[15:8]});
      check(ind_lower_threshold_out, LWR);
      host.xfer({8'h0A, 8'h00});
      hi_exp = 1'b1;
      host.xfer({8'h20, 8'hFF});
      check(converter_status_out, st_exp());
      feed(UPR);
      feed(UPR + 16'h0001);
      feed(LWR);
      feed(LWR - 16'h0001);
      for (int i = 0; i < 48; i++) begin
         seed = lfsr(seed);
         {no_oscillation_error_in, res_hysteresis_flag_in} = seed[17:16];
         res_high_compare_flag_in = seed[18];
         feed(seed[15:0]);
      end
      feed(16'hFFFF);
      host.xfer({8'h0A, 8'h08});
      check(converter_status_out, st_exp());
      check(interrupt_function_select_out, 16'h0008);
      host.xfer({8'h0A, 8'h00});
      hi_exp = 1'b1;
      check(converter_status_out, st_exp());
      new_data_in = 1'b1;
      rdy_exp = 1'b0;
      @(negedge mclk_in);
      new_data_in = 1'b0;
      @(negedge mclk_in);
      check(converter_status_out, st_exp());
      rd(7'h20, 8'hFF, st_exp());
      rdy_exp = 1'b1;
      check(converter_status_out, st_exp());
      rd(7'h7F, 8'hFF, 8'h00);
      check(q.size(), 16'h0000);
      complete_run();
   end
endmodule : itc_threshold_compare_tb
